/* rtl/gpb_top.sv */
// gpio port bank: 37 pins in five ports, event detection, apb register slave
// assumes pins asynchronous to MCLK; external pads resolve out/oe_n/pull-up
//
// Function
// [RULE_01] 37 pins: ports 0,1,2,4 of eight bits, port 3 of five.
// [RULE_02] port 0 pins bidirectional with events driving irq, smi, power-up request.
// [RULE_03] port 1 bidirectional with events, except bit 5 output only.
// [RULE_04] ports 2 and 3 bidirectional, no event detection.
// [RULE_05] runtime window sixteen-byte aligned, low address bits pick register.
// [RULE_06] runtime offsets: ports 0,1,4 at 00,04,0c; ports 2,3 at 08,0a.
// [RULE_07] event ports have out, in, enable and flag registers.
// [RULE_08] ports 2 and 3 have only out and in registers.
// [RULE_09] every pin owns a seven-bit configuration register.
// [RULE_10] ports 2 and 3 implement config bits 3-0 only; 6-4 reserved.
// [RULE_11] indices f0,f1,f2: selector, config window, event routing; f0 and f2 reset 00h.
// [RULE_12] selector bits 6-4 choose port 0 to 4; other codes reserved.
// [RULE_13] selector bits 2-0 choose pin; bits 7 and 3 reserved.
// [RULE_14] selector resets to zero, port 0 pin 0.
// [RULE_15] config window reads and writes the selected pin's register.
// [RULE_16] pin configs reset to 44h for ports 0,1,4 and 04h for 2,3.
// [RULE_17] layout: debounce, polarity, type, lock, pull-up, output type, enable.
// [RULE_18] interrupt type resets to 03h, only bit 1 writable.
// [RULE_19] base low byte bits 3-0 read-only zero.
// [RULE_20] lock clears only at reset; freezes direction, type, pull-up, output value.
// [RULE_21] polarity 0 falling or low, 1 rising or high.
// [RULE_22] event type 0 edge, 1 level.
// [RULE_23] output type 0 open-drain, 1 push-pull; enable 0 leaves pin undriven.
// [RULE_24] enabled events set sticky w1c flags; set enabled flags request interrupt.
`timescale 1ns/1ps
module gpb_top #(
    parameter int DEB_CYCLES = gpb_pkg::DEB_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [gpb_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [gpb_pkg::NPIN-1:0] GPIO_IN,
    output logic [gpb_pkg::NPIN-1:0] GPIO_OUT,
    output logic [gpb_pkg::NPIN-1:0] GPIO_OE_N,
    output logic [gpb_pkg::NPIN-1:0] GPIO_PULLUP,
    output logic IRQ_LINE,
    output logic SYSTEM_MGMT_INTERRUPT_N,
    output logic POWER_UP_REQUEST_N
);

    localparam int NS = gpb_pkg::NSLOT;
    localparam int NP = gpb_pkg::NPIN;
    localparam int DW = gpb_pkg::DEB_W;

    if (DEB_CYCLES < 1 || DEB_CYCLES > (1 << gpb_pkg::DEB_W))
    begin : g_chk
        $error("DEB_CYCLES out of range");
    end

    function automatic bit pin_exists(input int p, input int b);
        return (p < gpb_pkg::NPORT) && !(p == 3 && b >= gpb_pkg::PORT3_W);
    endfunction : pin_exists

    function automatic bit evt_pin(input int p, input int b);
        return (p == 0 || p == 4 || p == gpb_pkg::OUT_ONLY_PORT)
            && !(p == gpb_pkg::OUT_ONLY_PORT && b == gpb_pkg::OUT_ONLY_BIT);
    endfunction : evt_pin

    function automatic int pin_index(input int p, input int b);
        return (p < 3) ? p * 8 + b : (p == 3) ? 24 + b : 29 + b;
    endfunction : pin_index

    function automatic bit is_mapped(input logic [7:0] idx);
        return (idx <= gpb_pkg::IDX_RUNTIME_END) || idx == gpb_pkg::IDX_ACTIVATE
            || idx == gpb_pkg::IDX_BASE_HI || idx == gpb_pkg::IDX_BASE_LO
            || idx == gpb_pkg::IDX_IRQ_NUM || idx == gpb_pkg::IDX_IRQ_KIND
            || idx == gpb_pkg::IDX_DMA_A || idx == gpb_pkg::IDX_DMA_B
            || idx == gpb_pkg::IDX_PIN_SEL || idx == gpb_pkg::IDX_PIN_CFG
            || idx == gpb_pkg::IDX_PIN_ROUTE;
    endfunction : is_mapped

    // synchroniser and slot mapping
    logic [NP-1:0] sync1_r;
    logic [NP-1:0] sync2_r;
    logic [NS-1:0] in_w;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            // idle high, matching the default pull-ups: no false edge after reset
            sync1_r <= '1;
            sync2_r <= '1;
        end
        else
        begin
            sync1_r <= GPIO_IN;
            sync2_r <= sync1_r;
        end
    end

    for (genvar gp = 0; gp < gpb_pkg::NPORT; gp++)
    begin : g_port
        for (genvar gb = 0; gb < 8; gb++)
        begin : g_bit
            if (pin_exists(gp, gb))
            begin : g_in
                assign in_w[gp*8+gb] = sync2_r[pin_index(gp, gb)]; // RULE_01
            end
            else
            begin : g_none
                assign in_w[gp*8+gb] = 1'b0;
            end
        end
    end

    // apb decode
    logic [7:0] idx_w;
    logic mapped_w;
    logic wr_w;
    logic w1c_w;
    logic [2:0] sel_port_w;
    logic [2:0] sel_pin_w;
    int sel_slot_w;
    logic sel_ok_w;
    logic [7:0] wbyte_w;

    assign idx_w = PADDR[9:2]; // RULE_05
    assign mapped_w = is_mapped(idx_w) && PADDR[1:0] == 2'b00 && PADDR[11:10] == 2'b00;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped_w;
    assign wr_w = PSEL && PENABLE && PWRITE && PSTRB[0] && mapped_w;
    assign wbyte_w = PWDATA[7:0];

    // configuration and bus state
    gpb_pkg::gpb_cfg_t cfg_r [NS]; // RULE_09
    gpb_pkg::gpb_cfg_t cfg_nxt [NS];
    logic [2:0] route_r [NS];
    logic [2:0] route_nxt [NS];
    logic [NS-1:0] out_r, out_nxt;
    logic [NS-1:0] en_r, en_nxt;
    logic [NS-1:0] flg_r, flg_nxt;
    logic [7:0] sel_r, sel_nxt;
    logic [7:0] act_r, act_nxt;
    logic [7:0] base_hi_r, base_hi_nxt;
    logic [7:0] base_lo_r, base_lo_nxt;
    logic [7:0] irqn_r, irqn_nxt;
    logic [7:0] kind_r, kind_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [NS-1:0] evt_w;

    assign sel_port_w = sel_r[6:4]; // RULE_12
    assign sel_pin_w = sel_r[2:0]; // RULE_13
    assign sel_slot_w = int'(sel_port_w) * 8 + int'(sel_pin_w);
    assign sel_ok_w = pin_exists(int'(sel_port_w), int'(sel_pin_w));
    assign w1c_w = wr_w && (idx_w == gpb_pkg::IDX_P0_FLG || idx_w == gpb_pkg::IDX_P1_FLG
        || idx_w == gpb_pkg::IDX_P4_FLG); // RULE_08

    function automatic logic [7:0] read_mux(input logic [7:0] idx);
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            gpb_pkg::IDX_P0_OUT: r = out_r[0 +: 8];
            gpb_pkg::IDX_P0_IN: r = in_w[0 +: 8];
            gpb_pkg::IDX_P0_EN: r = en_r[0 +: 8];
            gpb_pkg::IDX_P0_FLG: r = flg_r[0 +: 8];
            gpb_pkg::IDX_P1_OUT: r = out_r[8 +: 8];
            gpb_pkg::IDX_P1_IN:
            begin
                r = in_w[8 +: 8];
                r[gpb_pkg::OUT_ONLY_BIT] = out_r[8 + gpb_pkg::OUT_ONLY_BIT]; // RULE_03
            end
            gpb_pkg::IDX_P1_EN: r = en_r[8 +: 8];
            gpb_pkg::IDX_P1_FLG: r = flg_r[8 +: 8];
            gpb_pkg::IDX_P2_OUT: r = out_r[16 +: 8];
            gpb_pkg::IDX_P2_IN: r = in_w[16 +: 8];
            gpb_pkg::IDX_P3_OUT: r = out_r[24 +: 8];
            gpb_pkg::IDX_P3_IN: r = in_w[24 +: 8];
            gpb_pkg::IDX_P4_OUT: r = out_r[32 +: 8];
            gpb_pkg::IDX_P4_IN: r = in_w[32 +: 8];
            gpb_pkg::IDX_P4_EN: r = en_r[32 +: 8];
            gpb_pkg::IDX_P4_FLG: r = flg_r[32 +: 8];
            gpb_pkg::IDX_ACTIVATE: r = act_r;
            gpb_pkg::IDX_BASE_HI: r = base_hi_r;
            gpb_pkg::IDX_BASE_LO: r = base_lo_r;
            gpb_pkg::IDX_IRQ_NUM: r = irqn_r;
            gpb_pkg::IDX_IRQ_KIND: r = kind_r;
            gpb_pkg::IDX_DMA_A: r = gpb_pkg::DMA_RPT;
            gpb_pkg::IDX_DMA_B: r = gpb_pkg::DMA_RPT;
            gpb_pkg::IDX_PIN_SEL: r = sel_r;
            gpb_pkg::IDX_PIN_CFG: r = sel_ok_w ? {1'b0, cfg_r[sel_slot_w]} : 8'h00; // RULE_15
            gpb_pkg::IDX_PIN_ROUTE: r = sel_ok_w ? {5'h00, route_r[sel_slot_w]} : 8'h00;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_mux

    always_comb
    begin
        logic [7:0] wm;
        gpb_pkg::gpb_cfg_t nc;
        int s;
        wm = 8'h00;
        nc = '0;
        s = 0;
        cfg_nxt = cfg_r;
        route_nxt = route_r;
        out_nxt = out_r;
        en_nxt = en_r;
        sel_nxt = sel_r;
        act_nxt = act_r;
        base_hi_nxt = base_hi_r;
        base_lo_nxt = base_lo_r;
        irqn_nxt = irqn_r;
        kind_nxt = kind_r;
        rdata_nxt = rdata_r;
        if (PSEL && !PENABLE && !PWRITE)
        begin
            rdata_nxt = {24'h000000, read_mux(idx_w)};
        end
        if (wr_w)
        begin
            unique case (idx_w)
                gpb_pkg::IDX_P0_OUT, gpb_pkg::IDX_P1_OUT, gpb_pkg::IDX_P2_OUT,
                gpb_pkg::IDX_P3_OUT, gpb_pkg::IDX_P4_OUT:
                begin
                    s = (idx_w == gpb_pkg::IDX_P0_OUT) ? 0 : (idx_w == gpb_pkg::IDX_P1_OUT) ? 8
                        : (idx_w == gpb_pkg::IDX_P2_OUT) ? 16 : (idx_w == gpb_pkg::IDX_P3_OUT)
                        ? 24 : 32; // RULE_06
                    for (int b = 0; b < 8; b++)
                    begin
                        if (pin_exists(s / 8, b) && !cfg_r[s+b].lock)
                        begin
                            out_nxt[s+b] = wbyte_w[b]; // RULE_20
                        end
                    end
                end
                gpb_pkg::IDX_P0_EN, gpb_pkg::IDX_P1_EN, gpb_pkg::IDX_P4_EN:
                begin
                    s = (idx_w == gpb_pkg::IDX_P0_EN) ? 0 : (idx_w == gpb_pkg::IDX_P1_EN) ? 8 : 32;
                    for (int b = 0; b < 8; b++)
                    begin
                        en_nxt[s+b] = wbyte_w[b] && evt_pin(s / 8, b); // RULE_07
                    end
                end
                gpb_pkg::IDX_ACTIVATE: act_nxt = wbyte_w;
                gpb_pkg::IDX_BASE_HI: base_hi_nxt = wbyte_w;
                gpb_pkg::IDX_BASE_LO: base_lo_nxt = wbyte_w & gpb_pkg::BASE_LO_WMASK; // RULE_19
                gpb_pkg::IDX_IRQ_NUM: irqn_nxt = wbyte_w;
                gpb_pkg::IDX_IRQ_KIND:
                begin
                    wm = gpb_pkg::KIND_WMASK;
                    kind_nxt = (wbyte_w & wm) | (gpb_pkg::KIND_RST & ~wm); // RULE_18
                end
                gpb_pkg::IDX_PIN_SEL: sel_nxt = wbyte_w & gpb_pkg::SEL_WMASK; // RULE_13
                gpb_pkg::IDX_PIN_CFG:
                begin
                    if (sel_ok_w) // RULE_15
                    begin
                        nc = gpb_pkg::gpb_cfg_t'(wbyte_w[6:0]); // RULE_17
                        if (cfg_r[sel_slot_w].lock)
                        begin
                            nc.lock = 1'b1; // RULE_20
                            nc.pu = cfg_r[sel_slot_w].pu;
                            nc.otype = cfg_r[sel_slot_w].otype;
                            nc.oe = cfg_r[sel_slot_w].oe;
                        end
                        if (sel_port_w == 3'd2 || sel_port_w == 3'd3)
                        begin
                            nc.deb = 1'b0; // RULE_10
                            nc.pol = 1'b0;
                            nc.typ = 1'b0;
                        end
                        cfg_nxt[sel_slot_w] = nc;
                    end
                end
                gpb_pkg::IDX_PIN_ROUTE:
                begin
                    if (sel_ok_w && evt_pin(int'(sel_port_w), int'(sel_pin_w)))
                    begin
                        route_nxt[sel_slot_w] = wbyte_w[2:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < NS; i++)
            begin
                cfg_r[i] <= (i / 8 == 2 || i / 8 == 3) ? gpb_pkg::CFG_RST_PLAIN[6:0]
                    : gpb_pkg::CFG_RST_EVT[6:0]; // RULE_16
                route_r[i] <= 3'h0; // RULE_11
            end
            out_r <= '0;
            en_r <= '0;
            sel_r <= 8'h00; // RULE_14
            act_r <= 8'h00;
            base_hi_r <= 8'h00;
            base_lo_r <= 8'h00;
            irqn_r <= 8'h00;
            kind_r <= gpb_pkg::KIND_RST;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            route_r <= route_nxt;
            out_r <= out_nxt;
            en_r <= en_nxt;
            sel_r <= sel_nxt;
            act_r <= act_nxt;
            base_hi_r <= base_hi_nxt;
            base_lo_r <= base_lo_nxt;
            irqn_r <= irqn_nxt;
            kind_r <= kind_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign PRDATA = rdata_r;

    // debounce and event detection
    logic [gpb_pkg::DEB_W-1:0] cnt_r [NS];
    logic [gpb_pkg::DEB_W-1:0] cnt_nxt [NS];
    logic [NS-1:0] filt_r, filt_nxt;
    logic [NS-1:0] prev_r, prev_nxt;

    always_comb
    begin
        int fs;
        // port 4 flags sit at slot 32, not 24
        fs = (idx_w[3:2] == 2'b11) ? 32 : int'(idx_w[3:2]) * 8;
        for (int i = 0; i < NS; i++)
        begin
            cnt_nxt[i] = '0;
            filt_nxt[i] = 1'b0;
            evt_w[i] = 1'b0;
            prev_nxt[i] = filt_r[i];
            if (evt_pin(i / 8, i % 8)) // RULE_02 RULE_04
            begin
                filt_nxt[i] = in_w[i];
                if (cfg_r[i].deb && in_w[i] != filt_r[i])
                begin
                    filt_nxt[i] = filt_r[i];
                    cnt_nxt[i] = cnt_r[i] + 1'b1;
                    if (cnt_r[i] == DW'(DEB_CYCLES - 1))
                    begin
                        filt_nxt[i] = in_w[i];
                        cnt_nxt[i] = '0;
                    end
                end
                evt_w[i] = cfg_r[i].typ ? (filt_r[i] == cfg_r[i].pol) // RULE_22
                    : (filt_r[i] == cfg_r[i].pol && prev_r[i] != cfg_r[i].pol); // RULE_21
            end
        end
        // set wins over the write-one clear
        flg_nxt = flg_r;
        if (w1c_w)
        begin
            for (int b = 0; b < 8; b++)
            begin
                flg_nxt[fs+b] = flg_r[fs+b] & ~wbyte_w[b];
            end
        end
        flg_nxt = flg_nxt | (evt_w & en_r); // RULE_24
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < NS; i++)
            begin
                cnt_r[i] <= '0;
            end
            filt_r <= '1;
            prev_r <= '1;
            flg_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            filt_r <= filt_nxt;
            prev_r <= prev_nxt;
            flg_r <= flg_nxt;
        end
    end

    // pin drivers and request outputs
    logic [NP-1:0] pin_o_r, pin_o_nxt;
    logic [NP-1:0] pin_oe_n_r, pin_oe_n_nxt;
    logic [NP-1:0] pin_pu_r, pin_pu_nxt;
    logic [2:0] req_w;
    logic irq_r, irq_nxt, smi_n_r, smi_n_nxt, pwu_n_r, pwu_n_nxt;

    always_comb
    begin
        int k;
        k = 0;
        pin_o_nxt = '0;
        pin_oe_n_nxt = '1;
        pin_pu_nxt = '0;
        req_w = 3'b000;
        for (int p = 0; p < gpb_pkg::NPORT; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (pin_exists(p, b))
                begin
                    k = pin_index(p, b);
                    pin_o_nxt[k] = out_r[p*8+b];
                    pin_oe_n_nxt[k] = !(cfg_r[p*8+b].oe
                        && (cfg_r[p*8+b].otype || !out_r[p*8+b])); // RULE_23
                    pin_pu_nxt[k] = cfg_r[p*8+b].pu;
                end
                if (flg_r[p*8+b] && en_r[p*8+b])
                begin
                    req_w = req_w | route_r[p*8+b]; // RULE_24
                end
            end
        end
        if (!act_r[gpb_pkg::ACT_BIT])
        begin
            req_w = 3'b000;
        end
        irq_nxt = kind_r[gpb_pkg::KIND_POL_BIT] ? req_w[gpb_pkg::ROUTE_IRQ]
            : !req_w[gpb_pkg::ROUTE_IRQ];
        smi_n_nxt = !req_w[gpb_pkg::ROUTE_SMI]; // RULE_02
        pwu_n_nxt = !req_w[gpb_pkg::ROUTE_PWU];
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            pin_o_r <= '0;
            pin_oe_n_r <= '1;
            pin_pu_r <= '0;
            irq_r <= 1'b0;
            smi_n_r <= 1'b1;
            pwu_n_r <= 1'b1;
        end
        else
        begin
            pin_o_r <= pin_o_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
            pin_pu_r <= pin_pu_nxt;
            irq_r <= irq_nxt;
            smi_n_r <= smi_n_nxt;
            pwu_n_r <= pwu_n_nxt;
        end
    end

    assign GPIO_OUT = pin_o_r;
    assign GPIO_OE_N = pin_oe_n_r;
    assign GPIO_PULLUP = pin_pu_r;
    assign IRQ_LINE = irq_r;
    assign SYSTEM_MGMT_INTERRUPT_N = smi_n_r;
    assign POWER_UP_REQUEST_N = pwu_n_r;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    property p_lock_sticky;
        cfg_r[16].lock |=> cfg_r[16].lock && $stable(cfg_r[16].oe) && $stable(out_r[16]);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock lost"); // RULE_20

    property p_edge_evt;
        !cfg_r[0].typ && filt_r[0] == cfg_r[0].pol && prev_r[0] != cfg_r[0].pol && en_r[0]
            |=> flg_r[0];
    endproperty
    a_edge_evt: assert property (p_edge_evt) else $error("edge missed"); // RULE_21

    property p_level_evt;
        cfg_r[8].typ && filt_r[8] == cfg_r[8].pol && en_r[8] |=> flg_r[8];
    endproperty
    a_level_evt: assert property (p_level_evt) else $error("level missed"); // RULE_22

    property p_plain_cfg;
        cfg_r[16][6:4] == 3'b000 && cfg_r[24][6:4] == 3'b000;
    endproperty
    a_plain_cfg: assert property (p_plain_cfg) else $error("plain cfg"); // RULE_10

    property p_sel_res;
        sel_r[7] == 1'b0 && sel_r[3] == 1'b0;
    endproperty
    a_sel_res: assert property (p_sel_res) else $error("sel reserved"); // RULE_13

    property p_base_lo;
        base_lo_r[3:0] == 4'h0;
    endproperty
    a_base_lo: assert property (p_base_lo) else $error("base low"); // RULE_19

    property p_kind_ro;
        (kind_r & ~gpb_pkg::KIND_WMASK) == (gpb_pkg::KIND_RST & ~gpb_pkg::KIND_WMASK);
    endproperty
    a_kind_ro: assert property (p_kind_ro) else $error("kind ro"); // RULE_18

    property p_out_only;
        flg_r[8+gpb_pkg::OUT_ONLY_BIT] == 1'b0 && flg_r[16 +: 16] == 16'h0000;
    endproperty
    a_out_only: assert property (p_out_only) else $error("flag on plain pin"); // RULE_03

    property p_push_pull;
        cfg_r[16].oe && cfg_r[16].otype |=> !GPIO_OE_N[16] && GPIO_OUT[16] == $past(out_r[16]);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("drive"); // RULE_23

    property p_flag_hold;
        flg_r[0] && !(w1c_w && idx_w == gpb_pkg::IDX_P0_FLG && wbyte_w[0]) |=> flg_r[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped"); // RULE_24

    c_evt: cover property (en_r[0] ##1 flg_r[0]);
    c_lock: cover property (wr_w && idx_w == gpb_pkg::IDX_PIN_CFG && cfg_r[0].lock);
    c_smi: cover property (!SYSTEM_MGMT_INTERRUPT_N);

endmodule : gpb_top

/* rtl/gpb_pkg.sv */
// package for the gpio port bank: register indices, field layout, resets, timing
// assumes registers are reached at byte address four times the index
package gpb_pkg;

    localparam int NPORT = 5;
    localparam int PORT_W = 8;
    localparam int PORT3_W = 5;
    localparam int NPIN = 37;
    localparam int NSLOT = NPORT * PORT_W;
    localparam int ADDR_W = 12;

    // runtime register indices
    localparam logic [7:0] IDX_P0_OUT = 8'h00;
    localparam logic [7:0] IDX_P0_IN = 8'h01;
    localparam logic [7:0] IDX_P0_EN = 8'h02;
    localparam logic [7:0] IDX_P0_FLG = 8'h03;
    localparam logic [7:0] IDX_P1_OUT = 8'h04;
    localparam logic [7:0] IDX_P1_IN = 8'h05;
    localparam logic [7:0] IDX_P1_EN = 8'h06;
    localparam logic [7:0] IDX_P1_FLG = 8'h07;
    localparam logic [7:0] IDX_P2_OUT = 8'h08;
    localparam logic [7:0] IDX_P2_IN = 8'h09;
    localparam logic [7:0] IDX_P3_OUT = 8'h0a;
    localparam logic [7:0] IDX_P3_IN = 8'h0b;
    localparam logic [7:0] IDX_P4_OUT = 8'h0c;
    localparam logic [7:0] IDX_P4_IN = 8'h0d;
    localparam logic [7:0] IDX_P4_EN = 8'h0e;
    localparam logic [7:0] IDX_P4_FLG = 8'h0f;
    localparam logic [7:0] IDX_RUNTIME_END = 8'h0f;

    // configuration register indices
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
    localparam logic [7:0] IDX_IRQ_KIND = 8'h71;
    localparam logic [7:0] IDX_DMA_A = 8'h74;
    localparam logic [7:0] IDX_DMA_B = 8'h75;
    localparam logic [7:0] IDX_PIN_SEL = 8'hf0;
    localparam logic [7:0] IDX_PIN_CFG = 8'hf1;
    localparam logic [7:0] IDX_PIN_ROUTE = 8'hf2;

    // reset values and masks
    localparam logic [7:0] CFG_RST_EVT = 8'h44;
    localparam logic [7:0] CFG_RST_PLAIN = 8'h04;
    localparam logic [7:0] KIND_RST = 8'h03;
    localparam logic [7:0] KIND_WMASK = 8'h02;
    localparam logic [7:0] DMA_RPT = 8'h04;
    localparam logic [7:0] BASE_LO_WMASK = 8'hf0;
    localparam logic [7:0] SEL_WMASK = 8'h77;
    localparam logic [7:0] ROUTE_WMASK = 8'h07;
    localparam int SEL_PORT_LSB = 4;
    localparam int ACT_BIT = 0;
    localparam int KIND_POL_BIT = 1;
    localparam int ROUTE_IRQ = 0;
    localparam int ROUTE_SMI = 1;
    localparam int ROUTE_PWU = 2;
    localparam int OUT_ONLY_PORT = 1;
    localparam int OUT_ONLY_BIT = 5;

    // debounce timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEBOUNCE_NS = 1000;
    localparam int DEB_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_W = 4;

    // per-pin configuration, bit 6 down to bit 0
    typedef struct packed {
        logic deb;
        logic pol;
        logic typ;
        logic lock;
        logic pu;
        logic otype;
        logic oe;
    } gpb_cfg_t;

endpackage : gpb_pkg

/* test/gpb_top_bench.sv */
// directed bench for the gpio port bank over apb
// assumes zero-wait apb slave, debounce shortened to 2
`timescale 1ns/1ps
module gpb_top_bench;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, irq, smi_n, pwu_n, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [36:0] gin = '1, gout, goe_n, gpu;
    int n_mismatch = 0;
    int n_compared = 0;
    gpb_top #(.DEB_CYCLES(2)) dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .GPIO_IN(gin), .GPIO_OUT(gout),
        .GPIO_OE_N(goe_n), .GPIO_PULLUP(gpu), .IRQ_LINE(irq),
        .SYSTEM_MGMT_INTERRUPT_N(smi_n), .POWER_UP_REQUEST_N(pwu_n));
    task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(0, idx, 8'h00);
        chk($sformatf("index %h", idx), {29'h0, exp}, {5'h0, rd});
    endtask : rchk
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 0;
        rchk(gpb_pkg::IDX_PIN_SEL, 8'h00);
        rchk(gpb_pkg::IDX_PIN_CFG, 8'h44);
        rchk(gpb_pkg::IDX_IRQ_KIND, 8'h03);
        chk("pull-ups", '1, gpu);
        $display("reset test done");
        bus(1, gpb_pkg::IDX_IRQ_KIND, 8'h00);
        rchk(gpb_pkg::IDX_IRQ_KIND, 8'h01);
        bus(1, gpb_pkg::IDX_IRQ_KIND, 8'h02);
        bus(1, gpb_pkg::IDX_BASE_LO, 8'hff);
        rchk(gpb_pkg::IDX_BASE_LO, 8'hf0);
        bus(1, gpb_pkg::IDX_PIN_SEL, 8'h20);
        rchk(gpb_pkg::IDX_PIN_CFG, 8'h04);
        bus(1, gpb_pkg::IDX_P2_OUT, 8'hff);
        bus(1, gpb_pkg::IDX_PIN_CFG, 8'hff);
        rchk(gpb_pkg::IDX_PIN_CFG, 8'h0f);
        bus(1, gpb_pkg::IDX_P2_OUT, 8'h00);
        bus(1, gpb_pkg::IDX_P4_OUT, 8'h3c);
        repeat (3) @(posedge mclk);
        chk("port2 out", 37'h0, {29'h0, gout[23:17], 1'b0 ^ ~gout[16]});
        chk("port2 pin0 drive", 37'h0, {36'h0, goe_n[16]});
        chk("port4 out", 37'h3c, {29'h0, gout[36:29]});
        bus(0, 8'h40, 8'h00);
        chk("unmapped error", 37'h1, {36'h0, err});
        $display("config test done");
        bus(1, gpb_pkg::IDX_PIN_SEL, 8'h00);
        bus(1, gpb_pkg::IDX_PIN_CFG, 8'h04);
        bus(1, gpb_pkg::IDX_P0_EN, 8'h01);
        bus(1, gpb_pkg::IDX_PIN_ROUTE, 8'h01);
        bus(1, gpb_pkg::IDX_ACTIVATE, 8'h01);
        @(posedge mclk);
        gin[1:0] <= 2'b00;
        repeat (12) @(posedge mclk);
        rchk(gpb_pkg::IDX_P0_FLG, 8'h01);
        rchk(gpb_pkg::IDX_P0_IN, 8'hfc);
        chk("irq", 37'h1, {36'h0, irq});
        gin[1:0] <= 2'b11;
        repeat (12) @(posedge mclk);
        bus(1, gpb_pkg::IDX_P0_FLG, 8'h01);
        rchk(gpb_pkg::IDX_P0_FLG, 8'h00);
        repeat (3) @(posedge mclk);
        chk("irq", 37'h0, {36'h0, irq});
        $display("event test done");
        bus(1, gpb_pkg::IDX_PIN_SEL, 8'h10);
        bus(1, gpb_pkg::IDX_PIN_CFG, 8'h14);
        bus(1, gpb_pkg::IDX_PIN_ROUTE, 8'h06);
        bus(1, gpb_pkg::IDX_P1_EN, 8'h01);
        bus(1, gpb_pkg::IDX_P4_EN, 8'h01);
        gin <= gin & ~37'h020000100;
        repeat (10) @(posedge mclk);
        rchk(gpb_pkg::IDX_P1_FLG, 8'h01);
        rchk(gpb_pkg::IDX_P4_FLG, 8'h01);
        chk("smi_n", 37'h0, {36'h0, smi_n});
        chk("pwu_n", 37'h0, {36'h0, pwu_n});
        bus(1, gpb_pkg::IDX_P1_FLG, 8'h01);
        rchk(gpb_pkg::IDX_P1_FLG, 8'h01);
        gin[8] <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1, gpb_pkg::IDX_P1_FLG, 8'h01);
        bus(1, gpb_pkg::IDX_P4_FLG, 8'h01);
        rchk(gpb_pkg::IDX_P1_FLG, 8'h00);
        rchk(gpb_pkg::IDX_P4_FLG, 8'h00);
        repeat (3) @(posedge mclk);
        chk("smi_n", 37'h1, {36'h0, smi_n});
        chk("pwu_n", 37'h1, {36'h0, pwu_n});
        $display("level test done");
        end_of_test();
    end
endmodule : gpb_top_bench
